// file: src/enc_pm_pkg.sv
// constants shared by the encoder counter and pattern match block
package enc_pm_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IO_W = 16;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_RELOAD = 8'h04;
    localparam logic [7:0] OFF_POSITION = 8'h08;
    localparam logic [7:0] OFF_INT_STATUS = 8'h0C;
    localparam logic [7:0] OFF_INT_MASK = 8'h10;
    localparam logic [7:0] OFF_PM_INDEX = 8'h14;
    localparam logic [7:0] OFF_PM_PATTERN = 8'h18;
    localparam logic [7:0] OFF_PM_ACTION = 8'h1C;
    localparam logic [7:0] OFF_PM_COUNT = 8'h20;
    localparam logic [7:0] OFF_OUT_STATE = 8'h24;
    localparam logic [7:0] OFF_GEN_PERIOD = 8'h28;
    localparam logic [7:0] OFF_PM_PTR = 8'h2C;
    // control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_RLD_EN = 2;
    localparam int CTRL_RLD_A = 3;
    localparam int CTRL_RLD_B = 4;
    localparam int CTRL_ORG_EN = 5;
    localparam int CTRL_PM_EN = 6;
    localparam int CTRL_PM_SRC = 7;
    localparam int CTRL_GEN_STOP = 8;
    localparam int CTRL_W = 8;
    localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
    // pattern action entry fields
    localparam int ACT_VAL_LSB = 0;
    localparam int ACT_TO_AO = 16;
    localparam int ACT_CONT = 17;
    localparam int ACT_IRQ = 18;
    localparam int ACT_OUT = 19;
    localparam int ACT_W = 20;
    // interrupt status bits
    localparam int INT_MATCH = 0;
    localparam int INT_RELOAD = 1;
    localparam int INT_W = 2;
    // reset values
    localparam logic [DATA_W-1:0] RELOAD_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] POS_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] GEN_PERIOD_RST = 32'h0000_0064;
    localparam logic [IO_W-1:0] OUT_RST = 16'h0000;
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [DATA_W-1:0] ONE_WORD = 32'h0000_0001;
    localparam logic [DATA_W-1:0] TWO_WORD = 32'h0000_0002;
    // input filter length in clock cycles
    localparam int DEBOUNCE_CYCLES = 4;
    typedef enum logic [1:0] {
        single_edge_quadrature_mode,
        double_rate_quadrature_mode,
        quadruple_rate_quadrature_mode,
        up_down_pulse_mode
    } count_mode_e;
endpackage

// file: src/sync_debounce.sv
// two-stage synchroniser with stable-level filter for one encoder input
`timescale 1ns/1ps
`default_nettype none
module sync_debounce #(
    parameter int STABLE = 4
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_async,
    output logic o_level
);
    localparam int CNT_W = $clog2(STABLE + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STABLE - 1);
    logic meta_r;
    logic sync_r;
    logic [CNT_W-1:0] cnt_r;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    // level accepted only after it has held for STABLE cycles
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= '0;
            o_level <= 1'b0;
        end else if (sync_r == o_level) begin
            cnt_r <= '0;
        end else if (cnt_r == CNT_LAST) begin
            cnt_r <= '0;
            o_level <= sync_r;
        end else begin
            cnt_r <= cnt_r + CNT_W'(1);
        end
    end
endmodule
`default_nettype wire

// file: src/encoder_index_reload_match.sv
// encoder position counter with index reload and pattern match actions
// Functional notes
// - reload condition is a chosen A and B level with index high
// - reload wins over a count step in the same cycle
// - counter takes preset value within one clock after condition is true
// - counting resumes from the loaded value with unchanged mode
// - with origin check on, reload needs index and origin both high
// - with origin check on, low origin suppresses reload
// - match engine compares input port code or position to stored patterns
// - up to 1024 pattern entries per channel
// - a match carries out its assigned action with no software step
// - match action targets analog or digital output as configured
// - digital action sets a static state or starts a running pattern
// - analog action sets a static level or starts a running waveform
// - each match may raise an interrupt, alone or with an output action
// - single-edge mode adds or subtracts one per quadrature cycle
// - double and quadruple modes change by two and four per cycle
// - up-down mode counts up on A pulses and down on B pulses
//
// The address map and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module encoder_index_reload_match #(
    parameter int DEPTH = 1024,
    parameter int DEBOUNCE = enc_pm_pkg::DEBOUNCE_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic i_phase_a_input,
    input wire logic i_phase_b_input,
    input wire logic i_index_input,
    input wire logic i_origin_input,
    input wire logic [enc_pm_pkg::IO_W-1:0] i_di,
    input wire logic [enc_pm_pkg::ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [enc_pm_pkg::DATA_W-1:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [enc_pm_pkg::DATA_W-1:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic [enc_pm_pkg::IO_W-1:0] o_do,
    output logic [enc_pm_pkg::IO_W-1:0] o_ao,
    output logic o_irq
);
    localparam int IDX_W = $clog2(DEPTH);
    localparam int CNT_W = IDX_W + 1;
    localparam int DW = enc_pm_pkg::DATA_W;
    localparam int IW = enc_pm_pkg::IO_W;

    logic rst_meta_r;
    logic rst_n;
    logic a_s, b_s, z_s, org_s;
    logic a_d_r, b_d_r;
    logic [enc_pm_pkg::CTRL_W-1:0] ctrl_r;
    logic [DW-1:0] reload_r;
    logic [DW-1:0] pos_r;
    logic [DW-1:0] gen_period_r;
    logic [DW-1:0] gen_cnt_r;
    logic [enc_pm_pkg::INT_W-1:0] int_status_r;
    logic [enc_pm_pkg::INT_W-1:0] int_mask_r;
    logic [IDX_W-1:0] pm_index_r;
    logic [CNT_W-1:0] pm_count_r;
    logic [IDX_W-1:0] pm_ptr_r;
    logic [DW-1:0] pat_mem [DEPTH];
    logic [enc_pm_pkg::ACT_W-1:0] act_mem [DEPTH];
    logic do_gen_r, ao_gen_r;
    logic [IW-1:0] ao_step_r;
    logic reload_cond_d_r;

    // reset release through two flops
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    sync_debounce #(.STABLE(DEBOUNCE)) u_sync_a (.i_core_clk(i_core_clk), .i_rst_n(rst_n),
        .i_async(i_phase_a_input), .o_level(a_s));
    sync_debounce #(.STABLE(DEBOUNCE)) u_sync_b (.i_core_clk(i_core_clk), .i_rst_n(rst_n),
        .i_async(i_phase_b_input), .o_level(b_s));
    sync_debounce #(.STABLE(DEBOUNCE)) u_sync_z (.i_core_clk(i_core_clk), .i_rst_n(rst_n),
        .i_async(i_index_input), .o_level(z_s));
    sync_debounce #(.STABLE(DEBOUNCE)) u_sync_o (.i_core_clk(i_core_clk), .i_rst_n(rst_n),
        .i_async(i_origin_input), .o_level(org_s));

    // ---- bus access ----
    logic bus_req, bus_wr;
    logic [DW-1:0] be_mask;
    logic [DW-1:0] rd_nxt;
    assign bus_req = i_avs_read | i_avs_write;
    assign bus_wr = i_avs_write & ~o_avs_waitrequest;
    assign be_mask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                      {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

    function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] wd,
                                            input logic [DW-1:0] m);
        merge = (old & ~m) | (wd & m);
    endfunction

    logic wr_ctrl, wr_pat, wr_act, wr_cnt, wr_idx, wr_w1c;
    assign wr_ctrl = bus_wr && (i_avs_address == enc_pm_pkg::OFF_CTRL);
    assign wr_pat = bus_wr && (i_avs_address == enc_pm_pkg::OFF_PM_PATTERN);
    assign wr_act = bus_wr && (i_avs_address == enc_pm_pkg::OFF_PM_ACTION);
    assign wr_cnt = bus_wr && (i_avs_address == enc_pm_pkg::OFF_PM_COUNT);
    assign wr_idx = bus_wr && (i_avs_address == enc_pm_pkg::OFF_PM_INDEX);
    assign wr_w1c = bus_wr && (i_avs_address == enc_pm_pkg::OFF_INT_STATUS);

    // one wait cycle then a single acknowledge cycle
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= enc_pm_pkg::ZERO_WORD;
        end else begin
            o_avs_waitrequest <= ~(bus_req & o_avs_waitrequest);
            if (i_avs_read && o_avs_waitrequest) begin
                o_avs_readdata <= rd_nxt;
            end
        end
    end

    always_comb begin
        rd_nxt = enc_pm_pkg::ZERO_WORD;
        if (i_avs_address == enc_pm_pkg::OFF_CTRL) begin
            rd_nxt = DW'(ctrl_r);
        end else if (i_avs_address == enc_pm_pkg::OFF_RELOAD) begin
            rd_nxt = reload_r;
        end else if (i_avs_address == enc_pm_pkg::OFF_POSITION) begin
            rd_nxt = pos_r;
        end else if (i_avs_address == enc_pm_pkg::OFF_INT_STATUS) begin
            rd_nxt = DW'(int_status_r);
        end else if (i_avs_address == enc_pm_pkg::OFF_INT_MASK) begin
            rd_nxt = DW'(int_mask_r);
        end else if (i_avs_address == enc_pm_pkg::OFF_PM_INDEX) begin
            rd_nxt = DW'(pm_index_r);
        end else if (i_avs_address == enc_pm_pkg::OFF_PM_PATTERN) begin
            rd_nxt = pat_mem[pm_index_r];
        end else if (i_avs_address == enc_pm_pkg::OFF_PM_ACTION) begin
            rd_nxt = DW'(act_mem[pm_index_r]);
        end else if (i_avs_address == enc_pm_pkg::OFF_PM_COUNT) begin
            rd_nxt = DW'(pm_count_r);
        end else if (i_avs_address == enc_pm_pkg::OFF_OUT_STATE) begin
            rd_nxt = {o_ao, o_do};
        end else if (i_avs_address == enc_pm_pkg::OFF_GEN_PERIOD) begin
            rd_nxt = gen_period_r;
        end else if (i_avs_address == enc_pm_pkg::OFF_PM_PTR) begin
            rd_nxt = DW'(pm_ptr_r);
        end
    end

    // software settings
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= enc_pm_pkg::CTRL_RST;
            reload_r <= enc_pm_pkg::RELOAD_RST;
            int_mask_r <= '0;
            gen_period_r <= enc_pm_pkg::GEN_PERIOD_RST;
        end else if (wr_ctrl) begin
            ctrl_r <= enc_pm_pkg::CTRL_W'(merge(DW'(ctrl_r), i_avs_writedata, be_mask));
        end else if (bus_wr && (i_avs_address == enc_pm_pkg::OFF_RELOAD)) begin
            reload_r <= merge(reload_r, i_avs_writedata, be_mask);
        end else if (bus_wr && (i_avs_address == enc_pm_pkg::OFF_INT_MASK)) begin
            int_mask_r <= enc_pm_pkg::INT_W'(merge(DW'(int_mask_r), i_avs_writedata, be_mask));
        end else if (bus_wr && (i_avs_address == enc_pm_pkg::OFF_GEN_PERIOD)) begin
            gen_period_r <= merge(gen_period_r, i_avs_writedata, be_mask);
        end
    end

    // ---- quadrature decode ----
    enc_pm_pkg::count_mode_e mode;
    logic a_rise, a_fall, b_rise, b_fall;
    logic step_up, step_dn;
    logic reload_cond;
    assign mode = enc_pm_pkg::count_mode_e'(ctrl_r[enc_pm_pkg::CTRL_MODE_LSB +: 2]);
    assign a_rise = a_s & ~a_d_r;
    assign a_fall = ~a_s & a_d_r;
    assign b_rise = b_s & ~b_d_r;
    assign b_fall = ~b_s & b_d_r;

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            a_d_r <= 1'b0;
            b_d_r <= 1'b0;
        end else begin
            a_d_r <= a_s;
            b_d_r <= b_s;
        end
    end

    always_comb begin
        step_up = 1'b0;
        step_dn = 1'b0;
        case (mode)
            enc_pm_pkg::single_edge_quadrature_mode: begin
                step_up = a_rise & ~b_s;
                step_dn = a_fall & ~b_s;
            end
            enc_pm_pkg::double_rate_quadrature_mode: begin
                step_up = (a_rise & ~b_s) | (a_fall & b_s);
                step_dn = (a_rise & b_s) | (a_fall & ~b_s);
            end
            enc_pm_pkg::quadruple_rate_quadrature_mode: begin
                step_up = (a_rise & ~b_s) | (a_fall & b_s) | (b_rise & a_s) | (b_fall & ~a_s);
                step_dn = (a_rise & b_s) | (a_fall & ~b_s) | (b_rise & ~a_s) | (b_fall & a_s);
            end
            default: begin
                step_up = a_rise & ~b_rise;
                step_dn = b_rise & ~a_rise;
            end
        endcase
    end

    // chosen A/B levels with index high, optionally qualified by origin
    assign reload_cond = ctrl_r[enc_pm_pkg::CTRL_RLD_EN] && z_s &&
                         (a_s == ctrl_r[enc_pm_pkg::CTRL_RLD_A]) &&
                         (b_s == ctrl_r[enc_pm_pkg::CTRL_RLD_B]) &&
                         (!ctrl_r[enc_pm_pkg::CTRL_ORG_EN] || org_s);

    // reload first, otherwise count from the current value
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_r <= enc_pm_pkg::POS_RST;
        end else if (reload_cond) begin
            pos_r <= reload_r;
        end else if (step_up) begin
            pos_r <= pos_r + enc_pm_pkg::ONE_WORD;
        end else if (step_dn) begin
            pos_r <= pos_r - enc_pm_pkg::ONE_WORD;
        end
    end

    // ---- pattern table ----
    always_ff @(posedge i_core_clk) begin
        if (wr_pat) begin
            pat_mem[pm_index_r] <= merge(pat_mem[pm_index_r], i_avs_writedata, be_mask);
        end
        if (wr_act) begin
            act_mem[pm_index_r] <= enc_pm_pkg::ACT_W'(i_avs_writedata);
        end
    end

    logic [DW-1:0] cmp_val;
    logic [enc_pm_pkg::ACT_W-1:0] act;
    logic [IW-1:0] act_val;
    logic match;
    assign cmp_val = ctrl_r[enc_pm_pkg::CTRL_PM_SRC] ? DW'(i_di) : pos_r;
    assign act = act_mem[pm_ptr_r];
    assign act_val = act[enc_pm_pkg::ACT_VAL_LSB +: IW];
    assign match = ctrl_r[enc_pm_pkg::CTRL_PM_EN] && (pm_count_r != '0) &&
                   (cmp_val == pat_mem[pm_ptr_r]);

    // index auto-advances after each action write; pointer walks the table on matches
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pm_index_r <= '0;
            pm_count_r <= '0;
            pm_ptr_r <= '0;
        end else begin
            if (wr_idx) begin
                pm_index_r <= IDX_W'(i_avs_writedata);
            end else if (wr_act) begin
                pm_index_r <= pm_index_r + IDX_W'(1);
            end
            if (wr_cnt) begin
                pm_count_r <= (i_avs_writedata > DW'(DEPTH)) ? CNT_W'(DEPTH)
                                                            : CNT_W'(i_avs_writedata);
                pm_ptr_r <= '0;
            end else if (match) begin
                pm_ptr_r <= (CNT_W'(pm_ptr_r) == pm_count_r - CNT_W'(1)) ? '0
                                                                         : pm_ptr_r + IDX_W'(1);
            end
        end
    end

    // ---- match actions and output generation ----
    logic gen_tick;
    assign gen_tick = (gen_cnt_r >= gen_period_r);

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gen_cnt_r <= enc_pm_pkg::ZERO_WORD;
        end else if (gen_tick) begin
            gen_cnt_r <= enc_pm_pkg::ZERO_WORD;
        end else begin
            gen_cnt_r <= gen_cnt_r + enc_pm_pkg::ONE_WORD;
        end
    end

    logic gen_stop;
    assign gen_stop = wr_ctrl && i_avs_writedata[enc_pm_pkg::CTRL_GEN_STOP];

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_do <= enc_pm_pkg::OUT_RST;
            do_gen_r <= 1'b0;
        end else if (match && act[enc_pm_pkg::ACT_OUT] && !act[enc_pm_pkg::ACT_TO_AO]) begin
            o_do <= act_val;
            do_gen_r <= act[enc_pm_pkg::ACT_CONT];
        end else if (gen_stop) begin
            do_gen_r <= 1'b0;
        end else if (do_gen_r && gen_tick) begin
            o_do <= {o_do[IW-2:0], o_do[IW-1]};
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_ao <= enc_pm_pkg::OUT_RST;
            ao_step_r <= enc_pm_pkg::OUT_RST;
            ao_gen_r <= 1'b0;
        end else if (match && act[enc_pm_pkg::ACT_OUT] && act[enc_pm_pkg::ACT_TO_AO]) begin
            ao_gen_r <= act[enc_pm_pkg::ACT_CONT];
            ao_step_r <= act_val;
            if (!act[enc_pm_pkg::ACT_CONT]) begin
                o_ao <= act_val;
            end
        end else if (gen_stop) begin
            ao_gen_r <= 1'b0;
        end else if (ao_gen_r && gen_tick) begin
            o_ao <= o_ao + ao_step_r;
        end
    end

    // ---- interrupts: set beats write-one-to-clear ----
    logic [enc_pm_pkg::INT_W-1:0] int_set, int_clr;
    always_comb begin
        int_set = '0;
        int_set[enc_pm_pkg::INT_MATCH] = match && act[enc_pm_pkg::ACT_IRQ];
        int_set[enc_pm_pkg::INT_RELOAD] = reload_cond && !reload_cond_d_r;
        int_clr = wr_w1c ? enc_pm_pkg::INT_W'(i_avs_writedata & be_mask) : '0;
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_status_r <= '0;
            reload_cond_d_r <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            int_status_r <= (int_status_r & ~int_clr) | int_set;
            reload_cond_d_r <= reload_cond;
            o_irq <= |(int_status_r & int_mask_r);
        end
    end

    // ---- assertions ----
    property p_reload_load;
        @(posedge i_core_clk) disable iff (!rst_n)
        reload_cond |=> pos_r == $past(reload_r);
    endproperty
    a_reload_load: assert property (p_reload_load) else $error("reload not taken");

    property p_reload_beats_step;
        @(posedge i_core_clk) disable iff (!rst_n)
        (reload_cond && (step_up || step_dn)) |=> pos_r == $past(reload_r);
    endproperty
    a_reload_beats_step: assert property (p_reload_beats_step) else $error("step beat reload");

    property p_origin_block;
        @(posedge i_core_clk) disable iff (!rst_n)
        (ctrl_r[enc_pm_pkg::CTRL_ORG_EN] && !org_s && !step_up && !step_dn) |=> $stable(pos_r);
    endproperty
    a_origin_block: assert property (p_origin_block) else $error("reload without origin");

    property p_single_up;
        @(posedge i_core_clk) disable iff (!rst_n)
        (mode == enc_pm_pkg::single_edge_quadrature_mode && a_rise && !b_s && !reload_cond)
        |=> pos_r == $past(pos_r) + enc_pm_pkg::ONE_WORD;
    endproperty
    a_single_up: assert property (p_single_up) else $error("single edge up step wrong");

    property p_double_quiet;
        @(posedge i_core_clk) disable iff (!rst_n)
        (mode == enc_pm_pkg::double_rate_quadrature_mode && !a_rise && !a_fall && !reload_cond)
        |=> $stable(pos_r);
    endproperty
    a_double_quiet: assert property (p_double_quiet) else $error("double rate counted on B");

    property p_updown_down;
        @(posedge i_core_clk) disable iff (!rst_n)
        (mode == enc_pm_pkg::up_down_pulse_mode && b_rise && !a_rise && !reload_cond)
        |=> pos_r == $past(pos_r) - enc_pm_pkg::ONE_WORD;
    endproperty
    a_updown_down: assert property (p_updown_down) else $error("down pulse not counted");

    property p_match_irq;
        @(posedge i_core_clk) disable iff (!rst_n)
        (match && act[enc_pm_pkg::ACT_IRQ]) |=> int_status_r[enc_pm_pkg::INT_MATCH] ##1 o_irq ||
        !int_mask_r[enc_pm_pkg::INT_MATCH];
    endproperty
    a_match_irq: assert property (p_match_irq) else $error("match interrupt missing");

    property p_match_do;
        @(posedge i_core_clk) disable iff (!rst_n)
        (match && act[enc_pm_pkg::ACT_OUT] && !act[enc_pm_pkg::ACT_TO_AO]) |=> o_do == $past(act_val);
    endproperty
    a_match_do: assert property (p_match_do) else $error("digital action missing");

    property p_match_ao;
        @(posedge i_core_clk) disable iff (!rst_n)
        (match && act[enc_pm_pkg::ACT_OUT] && act[enc_pm_pkg::ACT_TO_AO] && !act[enc_pm_pkg::ACT_CONT])
        |=> o_ao == $past(act_val) && !ao_gen_r;
    endproperty
    a_match_ao: assert property (p_match_ao) else $error("analog action missing");

    c_reload: cover property (@(posedge i_core_clk) disable iff (!rst_n) reload_cond ##1 step_up);
    c_match_irq: cover property (@(posedge i_core_clk) disable iff (!rst_n) match ##1 o_irq);
    c_quad_step: cover property (@(posedge i_core_clk) disable iff (!rst_n)
        mode == enc_pm_pkg::quadruple_rate_quadrature_mode && step_dn);
    c_ao_wave: cover property (@(posedge i_core_clk) disable iff (!rst_n) ao_gen_r && gen_tick);
endmodule
`default_nettype wire

// file: src/placeholder_unused.sv
// intentionally minimal: no extra logic in this file
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: sim/enc_model.sv
// quadrature encoder partner driving phases, index and origin
`timescale 1ns/1ps
`default_nettype none
module enc_model (
    input wire logic i_clk,
    output logic o_a,
    output logic o_b,
    output logic o_z,
    output logic o_org
);
    initial {o_a, o_b, o_z, o_org} = 4'h0;
    task automatic put(input logic [3:0] v);
        repeat (8) @(posedge i_clk);
        {o_a, o_b, o_z, o_org} <= v;
    endtask
    // one quadrature cycle, index and origin held for the first three steps, all low on the last
    task automatic turn(input logic fwd, input logic z, input logic org);
        put({fwd, ~fwd, z, org});
        put({2'h3, z, org});
        put({~fwd, fwd, z, org});
        put(4'h0);
    endtask
endmodule
`default_nettype wire

// file: sim/testbench.sv
// self-checking bench for the encoder counter with pattern match
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [15:0] di = 16'h0000;
    logic [31:0] rdat;
    logic [15:0] do_o, ao_o, ao_s;
    logic waitreq, irq, a, b, z, org;
    int miscompares = 0;
    int tests_run = 0;
    always #2.5 clk = ~clk;
    enc_model enc_model_i (.i_clk(clk), .o_a(a), .o_b(b), .o_z(z), .o_org(org));
    encoder_index_reload_match #(.DEPTH(4), .DEBOUNCE(1)) encoder_index_reload_match_i (
        .i_core_clk(clk), .i_arst_n(rst_n), .i_phase_a_input(a), .i_phase_b_input(b),
        .i_index_input(z), .i_origin_input(org), .i_di(di), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
        .o_avs_readdata(rdat), .o_avs_waitrequest(waitreq), .o_do(do_o), .o_ao(ao_o),
        .o_irq(irq));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        rd <= ~w;
        wr <= w;
        adr <= ad;
        wd <= d;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        if (waitreq !== 1'b0) begin
            miscompares++;
            finish_test();
        end
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk(input logic [7:0] ad, input logic [31:0] exp, input int wt);
        repeat (wt) @(posedge clk);
        xfer(1'b0, ad, 32'h0);
        cmp($sformatf("reg %h", ad), exp, rdat);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk(8'h00, 32'h0, 0);
        chk(8'h28, enc_pm_pkg::GEN_PERIOD_RST, 0);
        chk(8'h30, 32'h0, 0);
        $display("test reset done");
        repeat (3) enc_model_i.turn(1'b1, 1'b0, 1'b0);
        chk(8'h08, 32'h3, 10);
        enc_model_i.turn(1'b0, 1'b0, 1'b0);
        chk(8'h08, 32'h2, 10);
        xfer(1'b1, 8'h00, 32'h1);
        enc_model_i.turn(1'b1, 1'b0, 1'b0);
        chk(8'h08, 32'h4, 10);
        xfer(1'b1, 8'h00, 32'h2);
        enc_model_i.turn(1'b0, 1'b0, 1'b0);
        chk(8'h08, 32'h0, 10);
        xfer(1'b1, 8'h00, 32'h3);
        repeat (2) begin
            enc_model_i.put(4'h8);
            enc_model_i.put(4'h0);
        end
        chk(8'h08, 32'h2, 10);
        enc_model_i.put(4'h4);
        enc_model_i.put(4'h0);
        chk(8'h08, 32'h1, 10);
        $display("test counting done");
        xfer(1'b1, 8'h04, 32'h10);
        xfer(1'b1, 8'h00, 32'h0C);
        enc_model_i.turn(1'b1, 1'b1, 1'b0);
        chk(8'h08, 32'h10, 10);
        enc_model_i.turn(1'b1, 1'b0, 1'b0);
        chk(8'h08, 32'h11, 10);
        chk(8'h0C, 32'h2, 0);
        xfer(1'b1, 8'h00, 32'h2C);
        enc_model_i.turn(1'b1, 1'b1, 1'b0);
        chk(8'h08, 32'h12, 10);
        enc_model_i.turn(1'b1, 1'b1, 1'b1);
        chk(8'h08, 32'h10, 10);
        $display("test reload done");
        xfer(1'b1, 8'h10, 32'h2);
        repeat (2) @(posedge clk);
        cmp("irq", 32'h1, {31'h0, irq});
        xfer(1'b1, 8'h0C, 32'h3);
        repeat (2) @(posedge clk);
        cmp("irq", 32'h0, {31'h0, irq});
        xfer(1'b1, 8'h14, 32'h0);
        xfer(1'b1, 8'h18, 32'h5A);
        xfer(1'b1, 8'h1C, 32'h000C_00A5);
        xfer(1'b1, 8'h20, 32'h1);
        xfer(1'b1, 8'h00, 32'hC0);
        di <= 16'h005A;
        repeat (4) @(posedge clk);
        cmp("do", 32'hA5, {16'h0, do_o});
        cmp("irq", 32'h0, {31'h0, irq});
        chk(8'h0C, 32'h1, 0);
        $display("test match done");
        xfer(1'b1, 8'h28, 32'h4);
        xfer(1'b1, 8'h14, 32'h0);
        xfer(1'b1, 8'h1C, 32'h000B_0003);
        @(posedge clk);
        di <= 16'h0000;
        repeat (2) @(posedge clk);
        ao_s = ao_o;
        repeat (5) @(posedge clk);
        cmp("ao wave", {16'h0, ao_s + 16'h0003}, {16'h0, ao_o});
        xfer(1'b1, 8'h00, 32'h1C0);
        ao_s = ao_o;
        repeat (5) @(posedge clk);
        cmp("ao stop", {16'h0, ao_s}, {16'h0, ao_o});
        xfer(1'b1, 8'h14, 32'h0);
        xfer(1'b1, 8'h18, 32'h10);
        xfer(1'b1, 8'h1C, 32'h0009_1234);
        xfer(1'b1, 8'h00, 32'h40);
        repeat (2) @(posedge clk);
        cmp("ao", 32'h1234, {16'h0, ao_o});
        chk(8'h24, 32'h1234_00A5, 0);
        $display("test output done");
        finish_test();
    end
endmodule
`default_nettype wire
